// [verilog/link_power_ctrl.v]
// Purpose: operating and power mode control of a serial link controller
// Assumes: aclk 100 MHz, one clock, synchronous active-low aresetn
// Notes: clock gating is reported by clk_run_r, not done here
//
// Overview of operation
// - Any reset source asserted forces reset mode from every mode.
// - In reset mode, state held at reset values; inputs and bus ignored.
// - Reset mode leaves for run only once all reset sources released.
// - Stop wakeup enters run; reception valid once clocks stable (rx_valid sets in run without F_CLK_STABLE).
// - Wait-clock bit clear: wait request enters wait mode, clocks run.
// - Device stops driving the bus one cycle after entering wait mode.
// - Wait mode: first passive-to-active edge wakes and raises interrupt.
// - Wait-clock bit set: wait or stop request enters stop, clocks off.
// - Stop mode: first passive-to-active edge raises non-maskable request.
// - Leaving stop records wakeup code as highest priority in vector.
// - Bus activity in a low-power mode exits low-power operation unless a loopback bit is set.
// - Low-power entry and exit leave control register contents unchanged.
// - With a loopback bit set, bus traffic does not wake the device.
// - Message waking both CPU and device from stop may be lost.
// - After analog loopback exits, wait for idle bus before talking.
// - Digital loopback feeds transmit back to receive, bus undriven.
`timescale 1ns/1ps
`include "link_power_map.vh"

module link_power_ctrl (
    input wire aclk,
    input wire aresetn,
    input wire por_n,
    input wire low_voltage_reset,
    input wire cpu_wait_req,
    input wire cpu_stop_req,
    input wire eof_seen,
    input wire core_tx,
    input wire digital_rx_in,
    output reg digital_tx_out,
    output reg rx_to_core,
    output reg clk_run_r,
    output reg wake_irq,
    output reg wake_nmi,
    output reg rx_valid,
    output reg [3:0] mode_out,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    localparam [3:0] M_RESET = 4'h1;
    localparam [3:0] M_RUN = 4'h2;
    localparam [3:0] M_WAIT = 4'h4;
    localparam [3:0] M_STOP = 4'h8;

    reg [3:0] mode_r, mode_nxt;
    reg [1:0] ctrl_one_r;
    reg [1:0] ctrl_two_r;
    reg [5:0] state_vec_r;
    reg [2:0] rx_sync_r;
    reg rx_stable_r;
    reg analog_loopback_bit_was_r;
    reg idle_wait_r;
    reg [`IDLE_W-1:0] idle_cnt_r;
    reg [3:0] aw_addr_r;
    reg aw_have_r, w_have_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;

    wire any_reset = ~aresetn | ~por_n | low_voltage_reset;
    wire wait_clock_mode_sel = ctrl_one_r[`F_WAIT_CLK_SEL];
    wire loop_any = ctrl_two_r[`F_ANALOG_LOOPBACK_BIT] | ctrl_two_r[`F_DIGITAL_LOOPBACK_BIT];
    wire digital_loopback_bit = ctrl_two_r[`F_DIGITAL_LOOPBACK_BIT];
    // Rising edge of the filtered bus level is passive-to-active
    wire rx_agree = (rx_sync_r[1] == rx_sync_r[2]);
    wire rx_rise = rx_agree & rx_sync_r[2] & ~rx_stable_r;
    wire wake_evt = rx_rise & ~loop_any;
    wire wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;

    // Pin synchroniser; stage 0 feeds only stage 1
    always @(posedge aclk) begin
        if (any_reset) begin
            rx_sync_r <= 3'h0;
            rx_stable_r <= 1'b0;
        end else begin
            rx_sync_r <= {rx_sync_r[1:0], digital_rx_in};
            if (rx_agree)
                rx_stable_r <= rx_sync_r[2];
        end
    end

    // Mode sequencing
    always @* begin
        mode_nxt = mode_r;
        case (mode_r)
            M_RESET: mode_nxt = M_RUN;
            M_RUN: begin
                if (cpu_stop_req & wait_clock_mode_sel)
                    mode_nxt = M_STOP;
                else if (cpu_wait_req & ~wait_clock_mode_sel)
                    mode_nxt = M_WAIT;
                else if (cpu_wait_req & wait_clock_mode_sel)
                    mode_nxt = M_STOP;
            end
            M_WAIT: if (wake_evt) mode_nxt = M_RUN;
            M_STOP: if (wake_evt) mode_nxt = M_RUN;
            default: mode_nxt = M_RESET;
        endcase
    end

    always @(posedge aclk) begin
        if (any_reset)
            mode_r <= M_RESET;
        else
            mode_r <= mode_nxt;
    end

    // Wake requests and status; registers not touched by wake
    always @(posedge aclk) begin
        if (any_reset) begin
            wake_irq <= 1'b0;
            wake_nmi <= 1'b0;
            clk_run_r <= 1'b1;
            rx_valid <= 1'b0;
            mode_out <= M_RESET;
        end else begin
            mode_out <= mode_nxt;
            wake_irq <= (mode_r == M_WAIT) & wake_evt;
            wake_nmi <= (mode_r == M_STOP) & wake_evt;
            clk_run_r <= (mode_nxt != M_STOP);
            // stop clears valid; back in run it sets without F_CLK_STABLE
            if (mode_r == M_STOP)
                rx_valid <= 1'b0;
            else if (ctrl_one_r[`F_CLK_STABLE] & (mode_nxt == M_RUN))
                rx_valid <= 1'b1;
            else if (mode_r == M_RUN)
                rx_valid <= rx_valid | (mode_nxt == M_RUN & ~idle_wait_r);
        end
    end

    // idle-bus wait after analog loopback exits
    always @(posedge aclk) begin
        if (any_reset) begin
            analog_loopback_bit_was_r <= 1'b0;
            idle_wait_r <= 1'b0;
            idle_cnt_r <= {`IDLE_W{1'b0}};
        end else begin
            analog_loopback_bit_was_r <= ctrl_two_r[`F_ANALOG_LOOPBACK_BIT];
            if (analog_loopback_bit_was_r & ~ctrl_two_r[`F_ANALOG_LOOPBACK_BIT]) begin
                idle_wait_r <= 1'b1;
                idle_cnt_r <= {`IDLE_W{1'b0}};
            end else if (idle_wait_r) begin
                if (rx_stable_r)
                    idle_cnt_r <= {`IDLE_W{1'b0}};
                else if (idle_cnt_r == `IDLE_CYC - 1)
                    idle_wait_r <= 1'b0;
                else
                    idle_cnt_r <= idle_cnt_r + 1'b1;
            end
        end
    end

    // Pin paths; active bus level is high on the transmit pin
    always @(posedge aclk) begin
        if (any_reset) begin
            digital_tx_out <= 1'b0;
            rx_to_core <= 1'b0;
        end else begin
            // no drive in wait; digital loopback keeps bus quiet
            digital_tx_out <= core_tx & (mode_r == M_RUN) & ~digital_loopback_bit
                & ~idle_wait_r;
            rx_to_core <= digital_loopback_bit ? core_tx : rx_stable_r;
        end
    end

    // stop wakeup code wins in vector
    always @(posedge aclk) begin
        if (any_reset)
            state_vec_r <= `SV_NONE;
        else if ((mode_r == M_STOP) & wake_evt)
            state_vec_r <= `SV_WAKEUP;
        else if (s_axi_arvalid & s_axi_arready
                 & (s_axi_araddr == `OFF_STATE_VEC))
            state_vec_r <= eof_seen ? `SV_EOF : `SV_NONE;
        else if (eof_seen & (state_vec_r != `SV_WAKEUP))
            state_vec_r <= `SV_EOF;
    end

    // AXI write side: address and data taken in either order
    always @(posedge aclk) begin
        if (any_reset) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
            ctrl_one_r <= `RST_CTRL_ONE;
            ctrl_two_r <= `RST_CTRL_TWO;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_addr_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                if (aw_addr_r == `OFF_CTRL_ONE & w_strb_r[0])
                    ctrl_one_r <= w_data_r[1:0];
                else if (aw_addr_r == `OFF_CTRL_TWO & w_strb_r[0])
                    ctrl_two_r <= w_data_r[1:0];
                else if (aw_addr_r != `OFF_CTRL_ONE
                         & aw_addr_r != `OFF_CTRL_TWO)
                    s_axi_bresp <= 2'h2;
            end
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // AXI read side; reading the vector clears a stale code
    always @(posedge aclk) begin
        if (any_reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
                `OFF_CTRL_ONE: s_axi_rdata <= {30'h0, ctrl_one_r};
                `OFF_CTRL_TWO: s_axi_rdata <= {30'h0, ctrl_two_r};
                `OFF_STATE_VEC: s_axi_rdata <= {26'h0, state_vec_r};
                `OFF_MODE_STAT: s_axi_rdata <= {27'h0, idle_wait_r,
                                                mode_r};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// [verilog/link_power_map.vh]
// Purpose: offsets, fields and reset values for the link power controller
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes: included by link_power_ctrl.v only
`ifndef LINK_POWER_MAP_VH
`define LINK_POWER_MAP_VH

`define OFF_CTRL_ONE 4'h0
`define OFF_CTRL_TWO 4'h4
`define OFF_STATE_VEC 4'h8
`define OFF_MODE_STAT 4'hC

// Control one fields
`define F_WAIT_CLK_SEL 0
`define F_CLK_STABLE 1
// Control two fields
`define F_ANALOG_LOOPBACK_BIT 0
`define F_DIGITAL_LOOPBACK_BIT 1

`define RST_CTRL_ONE 2'h0
`define RST_CTRL_TWO 2'h0

// State vector codes
`define SV_NONE 6'h00
`define SV_EOF 6'h04
`define SV_WAKEUP 6'h20

// Idle bus: passive samples needed after analog loopback ends
`define IDLE_NS 300000
`define IDLE_CYC ((`IDLE_NS + 9) / 10)
`define IDLE_W 15

`endif

// [verilog/unused_placeholder_none.v]
`timescale 1ns/1ps

// [tb/link_power_sva.sv]
// Purpose: port assertions for the link power controller
// Assumes: one clock, sync active-low aresetn
// Notes: bound to the design at the foot of this file
`timescale 1ns/1ps
module link_power_sva (
    input wire aclk,
    input wire aresetn,
    input wire por_n,
    input wire low_voltage_reset,
    input wire digital_tx_out,
    input wire clk_run_r,
    input wire wake_irq,
    input wire wake_nmi,
    input wire [3:0] mode_out,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata
);
    // Reset sources other than aresetn, which disables the checks
    wire src = !por_n || low_voltage_reset;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    rst_mode_a: assert property (src |=> mode_out == 4'h1)
        else $error("reset source did not force reset mode");
    rst_quiet_a: assert property
        (src |=> !digital_tx_out && !s_axi_rvalid)
        else $error("outputs active in reset mode");
    rst_exit_a: assert property (src ##1 !src |=> mode_out == 4'h2)
        else $error("no run mode after reset release");
    wait_clk_a: assert property (mode_out == 4'h4 |-> clk_run_r)
        else $error("clocks halted in wait mode");
    wait_quiet_a: assert property
        (mode_out == 4'h4 && $past(mode_out) == 4'h4 |-> !digital_tx_out)
        else $error("bus driven in wait mode");
    irq_wake_a: assert property
        (wake_irq |-> mode_out == 4'h2 ##1 !wake_irq)
        else $error("wait wakeup pulse wrong");
    stop_clk_a: assert property (mode_out == 4'h8 |-> !clk_run_r)
        else $error("clocks running in stop mode");
    nmi_wake_a: assert property
        (wake_nmi |-> mode_out == 4'h2 ##1 !wake_nmi)
        else $error("stop wakeup pulse wrong");
    rdata_hold_a: assert property
        (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    cover property (wake_irq);
    cover property (wake_nmi);
    cover property (src ##1 !src);
endmodule
bind link_power_ctrl link_power_sva i_link_power_sva (.aclk, .aresetn,
    .por_n, .low_voltage_reset, .digital_tx_out, .clk_run_r, .wake_irq,
    .wake_nmi, .mode_out, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// [tb/bus_node.sv]
// Purpose: far-side bus node making bursts of activity
// Assumes: passive bus level is low
// Notes: bus is released to passive low between bursts
`timescale 1ns/1ps
module bus_node (
    input wire aclk,
    input wire go,
    input wire [7:0] len,
    output logic rx
);
    logic [7:0] cnt_r = 8'h00;
    // Active level held len cycles; long enough to pass the sync
    always @(posedge aclk) begin
        if (go)
            cnt_r <= len;
        else if (cnt_r != 8'h00)
            cnt_r <= cnt_r - 8'h01;
    end
    assign rx = (cnt_r != 8'h00);
endmodule

// [tb/tb.sv]
// Purpose: self-checking bench for the link power controller
// Assumes: 100 MHz aclk, reset held 12 cycles
// Notes: read results checked from a queue by a monitor
`timescale 1ns/1ps
module tb;
    logic aclk = 0, aresetn = 0, por_n = 1, low_voltage_reset = 0;
    logic cpu_wait_req = 0, cpu_stop_req = 0, eof_seen = 0, core_tx = 0;
    logic digital_rx_in, go = 0, digital_tx_out, rx_to_core, clk_run_r;
    logic wake_irq, wake_nmi, rx_valid, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [7:0] len = 8'h00;
    logic [3:0] mode_out, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [63:0] exp_q [$];
    int error_cnt = 0, samples_checked = 0;
    link_power_ctrl i_link_power_ctrl (.aclk, .aresetn, .por_n,
        .low_voltage_reset, .cpu_wait_req, .cpu_stop_req, .eof_seen,
        .core_tx, .digital_rx_in, .digital_tx_out, .rx_to_core, .clk_run_r,
        .wake_irq, .wake_nmi, .rx_valid, .mode_out, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    bus_node i_bus_node (.aclk, .go, .len, .rx(digital_rx_in));
    // 100 MHz clock
    initial forever #5 aclk = ~aclk;
    task chk(input logic [31:0] g, e, input string s);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, s);
        end
    endtask
    // Write: address and data offered together, each dropped when taken
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bready && s_axi_bvalid) begin
                s_axi_bready <= 0;
                chk({30'h0, s_axi_bresp}, 32'h0, "bresp");
            end
        end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
    endtask
    // Read: expectation queued first, monitor compares the beat
    task rd(input logic [3:0] a, input logic [31:0] e, m);
        exp_q.push_back({e, m});
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) s_axi_rready <= 0;
        end while (s_axi_arvalid || s_axi_rready);
    endtask
    // Oldest expectation meets each accepted read beat
    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            chk(s_axi_rdata & exp_q[0][31:0], exp_q[0][63:32], "rdata");
            void'(exp_q.pop_front());
        end
    end
    // One-cycle low-power request; level would re-enter after wakeup
    task req(input logic stop, input logic [3:0] m);
        @(posedge aclk);
        {cpu_stop_req, cpu_wait_req} <= {stop, !stop};
        @(posedge aclk);
        {cpu_stop_req, cpu_wait_req} <= 2'h0;
        repeat (3) @(posedge aclk);
        chk({28'h0, mode_out}, {28'h0, m}, "mode after request");
    endtask
    // Random-length activity burst, then look for the wake pulse
    task wake(input logic nmi, input logic e);
        logic seen;
        seen = 0;
        @(posedge aclk);
        {go, len} <= {1'b1, 8'h08 + 8'($urandom % 16)};
        @(posedge aclk);
        go <= 0;
        repeat (40) begin
            @(posedge aclk);
            if ((nmi ? wake_nmi : wake_irq) === 1'b1) seen = 1;
        end
        chk({31'h0, seen}, {31'h0, e}, "wake pulse");
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #500000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        void'($urandom(29));
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        rd(4'h0, 32'h0, 32'h3);
        rd(4'h4, 32'h0, 32'h3);
        rd(4'hC, 32'h2, 32'hF);
        $display("reset values done");
        // Software keeps the bus quiet before low power
        wr(4'h0, 32'h0);
        req(1'b1, 4'h2);
        req(1'b0, 4'h4);
        wake(1'b0, 1'b1);
        rd(4'hC, 32'h2, 32'hF);
        $display("wait mode done");
        @(posedge aclk);
        eof_seen <= 1;
        @(posedge aclk);
        eof_seen <= 0;
        rd(4'h8, 32'h4, 32'h3F);
        wr(4'h0, 32'h1);
        req(1'b1, 4'h8);
        chk({31'h0, rx_valid}, 32'h0, "rx valid in stop");
        wake(1'b1, 1'b1);
        rd(4'h8, 32'h20, 32'h3F);
        rd(4'h0, 32'h1, 32'h1);
        chk({31'h0, rx_valid}, 32'h1, "rx valid after wake");
        $display("stop mode done");
        wr(4'h0, 32'h0);
        wr(4'h4, 32'h2);
        core_tx <= 1;
        repeat (6) @(posedge aclk);
        chk({31'h0, rx_to_core}, 32'h1, "loopback rx");
        chk({31'h0, digital_tx_out}, 32'h0, "loopback tx");
        core_tx <= 0;
        req(1'b0, 4'h4);
        wake(1'b0, 1'b0);
        wr(4'h4, 32'h0);
        wake(1'b0, 1'b1);
        $display("loopback done");
        // Analog loopback set then cleared starts the idle-bus wait
        wr(4'h4, 32'h1);
        wr(4'h4, 32'h0);
        core_tx <= 1;
        rd(4'hC, 32'h12, 32'h1F);
        chk({31'h0, digital_tx_out}, 32'h0, "idle wait tx");
        core_tx <= 0;
        $display("idle wait done");
        for (int i = 0; i < 2; i++) begin
            wr(4'h0, 32'h1);
            {por_n, low_voltage_reset} <= (i == 0) ? 2'h3 : 2'h0;
            repeat (2) @(posedge aclk);
            chk({28'h0, mode_out}, 32'h1, "reset mode");
            {por_n, low_voltage_reset} <= 2'h2;
            repeat (2) @(posedge aclk);
            chk({28'h0, mode_out}, 32'h2, "run mode");
            rd(4'h0, 32'h0, 32'h1);
        end
        $display("reset sources done");
        report_and_stop();
    end
endmodule
